// file: rtl/spmsp_pkg.sv
// Constants and types of the byte-wide serial port (master or slave).
// Assumes a single 250 MHz clock and a byte-wide register port.
// Contract
// - Interrupt request follows done or fault flag when interrupt enable is one.
// - Output enable hands pins to the port; zero leaves them to general I/O.
// - Reset clears output enable, so pins start disconnected.
// - Select low in master role clears output enable and master select.
// - Master select drives the clock out and swaps data pin roles.
// - Clock idle level bit sets the resting clock level in both roles.
// - Capture phase bit picks first or second transition as first capture.
// - Master clock divider by three rate bits: /4 up to /128.
// - In slave role the rate bits do nothing; clock comes from master.
// - Done flag set at byte end; cleared by status then data access.
// - Data writes are ignored while the done flag is set.
// - Data write during a transfer sets the read-only collision flag.
// - Fault flag set by select low in master; status access then control write clears.
// - Only a data write starts a master byte exchange.
// - Received byte is copied to a receive buffer; data reads return it.
// - Data write loads the shift register directly.
// - Upper control bits and status reset to zero.
// - Output enable and master cannot be set while fault flag stands, except by the control write after a status access.
// - Collision raises no interrupt; collided write dropped, transfer continues.

package spmsp_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] SPMSP_OFS_DATA = 8'h21;
	localparam logic [7:0] SPMSP_OFS_CTRL = 8'h22;
	localparam logic [7:0] SPMSP_OFS_STAT = 8'h23;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int SPMSP_ST_DONE  = 7;
	localparam int SPMSP_ST_WRITE_COLLISION_FLAG  = 6;
	localparam int SPMSP_ST_MODE_FAULT_FLAG  = 4;
	localparam int SPMSP_CR_OE    = 6;
	localparam int SPMSP_CR_MASTER_SELECT  = 4;
	localparam logic [7:0] SPMSP_CTRL_RST = 8'h00;
	localparam logic [7:0] SPMSP_STAT_RST = 8'h00;
	localparam logic [7:0] SPMSP_DATA_RST = 8'h00;

	// ************************************************************
	// Timing counts: half serial clock periods in CPU cycles, and the index of the last clock edge of a byte
	// ************************************************************
	localparam logic [6:0] SPMSP_HALF_DIV4   = 7'h02;
	localparam logic [6:0] SPMSP_HALF_DIV8   = 7'h04;
	localparam logic [6:0] SPMSP_HALF_DIV16  = 7'h08;
	localparam logic [6:0] SPMSP_HALF_DIV32  = 7'h10;
	localparam logic [6:0] SPMSP_HALF_DIV64  = 7'h20;
	localparam logic [6:0] SPMSP_HALF_DIV128 = 7'h40;
	localparam logic [4:0] SPMSP_LAST_EDGE   = 5'h0F;

	// Control register layout
	typedef struct packed {
		logic irq_enable;
		logic port_output_enable;
		logic rate_div_high;
		logic master_select;
		logic clock_idle_level;
		logic clock_capture_phase;
		logic rate_sel_mid;
		logic rate_sel_low;
	} spmsp_ctrl_t;

endpackage

// file: rtl/spmsp_top.sv
// Byte-wide serial port, master or slave, with its register port.
// Assumes pin inputs are synchronous to CLK_I; pin wires are resolved outside.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`default_nettype none

module spmsp_top (
	input  wire logic       CLK_I,
	input  wire logic       RST_N_I,
	input  wire logic [7:0] ADDR_I,
	input  wire logic [7:0] WDATA_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	output logic      [7:0] RDATA_O,
	output logic            IRQ_O,
	input  wire logic       SCK_I,
	output logic            SCK_O,
	output logic            SCK_OE_O,
	input  wire logic       MOSI_I,
	output logic            MOSI_O,
	output logic            MOSI_OE_O,
	input  wire logic       MISO_I,
	output logic            MISO_O,
	output logic            MISO_OE_O,
	input  wire logic       SS_N_I
);

	// ************************************************************
	// Functions
	// ************************************************************

	// Half period of the master clock for a rate code {high, mid, low}
	function automatic logic [6:0] half_period(input logic [2:0] code);
		logic [6:0] h;
		h = spmsp_pkg::SPMSP_HALF_DIV128;
		case (code)
			3'h4: h = spmsp_pkg::SPMSP_HALF_DIV4;
			3'h0: h = spmsp_pkg::SPMSP_HALF_DIV8;
			3'h1: h = spmsp_pkg::SPMSP_HALF_DIV16;
			3'h6: h = spmsp_pkg::SPMSP_HALF_DIV32;
			3'h2: h = spmsp_pkg::SPMSP_HALF_DIV64;
			default: h = spmsp_pkg::SPMSP_HALF_DIV128;
		endcase
		return h;
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	spmsp_pkg::spmsp_ctrl_t ctrl_q;
	logic       done_q;
	logic       write_collision_flag_q;
	logic       mode_fault_flag_q;
	logic       stat_seen_q;
	logic       mode_fault_flag_seen_q;
	logic       busy_q;
	logic [4:0] edge_cnt_q;
	logic [6:0] div_q;
	logic       sck_q;
	logic       sck_prev_q;
	logic       out_q;
	logic [7:0] shift_q;
	logic [7:0] rxbuf_q;
	logic [7:0] rdata_q;
	logic       irq_q;
	logic       sck_oe_q;
	logic       mosi_oe_q;
	logic       miso_oe_q;

	// ************************************************************
	// Decode and events
	// ************************************************************
	logic       wr_data;
	logic       rd_data;
	logic       wr_ctrl;
	logic       acc_stat;
	logic       is_master;
	logic       fault;
	logic       slave_sel;
	logic       xfer_busy;
	logic       data_take;
	logic       collide;
	logic       start;
	logic       tick;
	logic       m_edge;
	logic       s_edge;
	logic       any_edge;
	logic       new_level;
	logic       lead;
	logic       capture;
	logic       launch;
	logic       last;
	logic       din;
	logic [6:0] half;
	logic       allow_set;

	// Register port strobes
	assign wr_data  = WR_I && (ADDR_I == spmsp_pkg::SPMSP_OFS_DATA);
	assign rd_data  = RD_I && (ADDR_I == spmsp_pkg::SPMSP_OFS_DATA);
	assign wr_ctrl  = WR_I && (ADDR_I == spmsp_pkg::SPMSP_OFS_CTRL);
	assign acc_stat = (WR_I || RD_I) && (ADDR_I == spmsp_pkg::SPMSP_OFS_STAT);

	// Role and fault
	assign is_master = ctrl_q.master_select;
	assign fault     = is_master && !SS_N_I;
	assign slave_sel = ctrl_q.port_output_enable && !is_master && !SS_N_I;

	// phase zero slave is frozen while selected
	assign xfer_busy = is_master ? busy_q
		: (slave_sel && (!ctrl_q.clock_capture_phase || edge_cnt_q != 5'h00));

	// writes ignored while done flag set
	assign data_take = wr_data && !done_q && !xfer_busy;
	assign collide   = wr_data && !done_q && xfer_busy;
	assign start     = data_take && is_master && ctrl_q.port_output_enable && !fault;

	assign half = half_period({ctrl_q.rate_div_high, ctrl_q.rate_sel_mid, ctrl_q.rate_sel_low});
	assign tick = (div_q == half - 7'h01);

	// slave edges come from the external clock only
	assign m_edge    = busy_q && is_master && tick;
	assign s_edge    = slave_sel && (SCK_I != sck_prev_q);
	assign any_edge  = m_edge || s_edge;
	assign new_level = is_master ? !sck_q : SCK_I;
	// capture on first or second transition
	assign lead      = (new_level != ctrl_q.clock_idle_level);
	assign capture   = any_edge && (lead != ctrl_q.clock_capture_phase);
	assign launch    = any_edge && (lead == ctrl_q.clock_capture_phase);
	assign last      = any_edge && (edge_cnt_q == spmsp_pkg::SPMSP_LAST_EDGE);
	// data pin roles swap with master select
	assign din       = is_master ? MISO_I : MOSI_I;

	// set of enable bits refused while fault flag stands, outside clearing sequence
	assign allow_set = !mode_fault_flag_q || mode_fault_flag_seen_q;

	// ************************************************************
	// Control register
	// ************************************************************
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			ctrl_q <= spmsp_pkg::SPMSP_CTRL_RST;
		else begin
			if (wr_ctrl)
			begin
				ctrl_q <= WDATA_I;
				ctrl_q.port_output_enable <= WDATA_I[spmsp_pkg::SPMSP_CR_OE]
					&& (allow_set || ctrl_q.port_output_enable);
				ctrl_q.master_select <= WDATA_I[spmsp_pkg::SPMSP_CR_MASTER_SELECT]
					&& (allow_set || ctrl_q.master_select);
			end
			if (fault)
			begin
				ctrl_q.port_output_enable <= 1'b0;
				ctrl_q.master_select      <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Status flags
	// ************************************************************

	// Arms the done and collision clearing sequence
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			stat_seen_q <= 1'b0;
		else if (acc_stat)
			stat_seen_q <= 1'b1;
		else if (wr_data || rd_data)
			stat_seen_q <= 1'b0;
	end

	// done flag, set wins over clear
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			done_q <= 1'b0;
		else if (last)
			done_q <= 1'b1;
		else if (stat_seen_q && (wr_data || rd_data))
			done_q <= 1'b0;
	end

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			write_collision_flag_q <= 1'b0;
		else if (collide)
			write_collision_flag_q <= 1'b1;
		else if (stat_seen_q && (wr_data || rd_data))
			write_collision_flag_q <= 1'b0;
	end

	// fault flag and its clearing sequence
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			mode_fault_flag_q      <= 1'b0;
			mode_fault_flag_seen_q <= 1'b0;
		end
		else begin
			if (fault)
				mode_fault_flag_q <= 1'b1;
			else if (mode_fault_flag_seen_q && wr_ctrl)
				mode_fault_flag_q <= 1'b0;
			if (wr_ctrl)
				mode_fault_flag_seen_q <= 1'b0;
			else if (acc_stat && mode_fault_flag_q)
				mode_fault_flag_seen_q <= 1'b1;
		end
	end

	// ************************************************************
	// Master clock generation
	// ************************************************************
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			busy_q <= 1'b0;
			div_q  <= 7'h00;
			sck_q  <= 1'b0;
		end
		else begin
			if (start)
				busy_q <= 1'b1;
			else if (fault || (is_master && last) || !is_master)
				busy_q <= 1'b0;
			if (!busy_q || tick)
				div_q <= 7'h00;
			else
				div_q <= div_q + 7'h01;
			if (!busy_q)
				sck_q <= ctrl_q.clock_idle_level;
			else if (m_edge)
				sck_q <= !sck_q;
		end
	end

	// ************************************************************
	// Bit engine
	// ************************************************************

	// Edge counter and external clock history
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			edge_cnt_q <= 5'h00;
			sck_prev_q <= 1'b0;
		end
		else begin
			sck_prev_q <= slave_sel ? SCK_I : ctrl_q.clock_idle_level;
			if (start || last || (!is_master && !slave_sel))
				edge_cnt_q <= 5'h00;
			else if (any_edge)
				edge_cnt_q <= edge_cnt_q + 5'h01;
		end
	end

	// Shift register, output bit and receive buffer
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			shift_q <= spmsp_pkg::SPMSP_DATA_RST;
			rxbuf_q <= spmsp_pkg::SPMSP_DATA_RST;
			out_q   <= 1'b0;
		end
		else begin
			if (data_take)
				shift_q <= WDATA_I;
			else if (capture)
				shift_q <= {shift_q[6:0], din};
			if (data_take)
				out_q <= WDATA_I[7];
			else if (launch)
				out_q <= shift_q[7];
			else if (!ctrl_q.clock_capture_phase && edge_cnt_q == 5'h00 && !busy_q)
				out_q <= shift_q[7];
			// copy received byte at the end
			if (last)
				rxbuf_q <= capture ? {shift_q[6:0], din} : shift_q;
		end
	end

	// ************************************************************
	// Register read and outputs
	// ************************************************************
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			rdata_q <= 8'h00;
		else if (RD_I)
		begin
			if (ADDR_I == spmsp_pkg::SPMSP_OFS_DATA)
				rdata_q <= rxbuf_q;
			else if (ADDR_I == spmsp_pkg::SPMSP_OFS_CTRL)
				rdata_q <= ctrl_q;
			else if (ADDR_I == spmsp_pkg::SPMSP_OFS_STAT)
				rdata_q <= {done_q, write_collision_flag_q, 1'b0, mode_fault_flag_q, 4'h0};
			else
				rdata_q <= 8'h00;
		end
		else
			rdata_q <= 8'h00;
	end

	// Interrupt and pin ownership
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			irq_q     <= 1'b0;
			sck_oe_q  <= 1'b0;
			mosi_oe_q <= 1'b0;
			miso_oe_q <= 1'b0;
		end
		else begin
			// only done and fault raise a request
			irq_q     <= ctrl_q.irq_enable && (done_q || mode_fault_flag_q);
			sck_oe_q  <= ctrl_q.port_output_enable && is_master && !fault;
			mosi_oe_q <= ctrl_q.port_output_enable && is_master && !fault;
			miso_oe_q <= slave_sel;
		end
	end

	assign RDATA_O   = rdata_q;
	assign IRQ_O     = irq_q;
	assign SCK_O     = sck_q;
	assign SCK_OE_O  = sck_oe_q;
	assign MOSI_O    = out_q;
	assign MOSI_OE_O = mosi_oe_q;
	assign MISO_O    = out_q;
	assign MISO_OE_O = miso_oe_q;

endmodule

`default_nettype wire

// file: bench/spmsp_slave_model.sv
// Far-side serial slave model: sends tx_i MSB first, collects the byte it hears.
// Assumes the pins are sampled on the system clock, each level two cycles or longer.
`timescale 1ns/1ns
`default_nettype none

module spmsp_slave_model (
	input  wire logic       clk_i,
	input  wire logic       sck_i,
	input  wire logic       mosi_i,
	input  wire logic       ss_n_i,
	input  wire logic       clock_idle_level_i,
	input  wire logic       clock_capture_phase_i,
	input  wire logic [7:0] tx_i,
	output logic            miso_o,
	output logic      [7:0] rx_o
);
	// ****
	// Edge tracking
	// ****
	logic       ph_q;
	logic [2:0] fall_q;
	logic       last_q = 1'b0;
	wire        ph  = sck_i ^ clock_idle_level_i ^ clock_capture_phase_i;
	wire  [2:0] idx = fall_q - {2'h0, clock_capture_phase_i};

	always @(posedge clk_i)
	begin
		ph_q   <= ph;
		last_q <= miso_o;
		if (ss_n_i)
			fall_q <= 3'h0;
		else if (ph && !ph_q)
			rx_o <= {rx_o[6:0], mosi_i};
		else if (!ph && ph_q)
			fall_q <= fall_q + 3'h1;
	end

	// Released line shows the inverse of its last bit
	assign miso_o = ss_n_i ? ~last_q : tx_i[3'h7 - idx];
endmodule

`default_nettype wire

// file: bench/spmsp_top_asserts.sv
// Checker on the serial port's top-level pins.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none

module spmsp_top_asserts (
	input wire logic       CLK_I,
	input wire logic       RST_N_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic       WR_I,
	input wire logic       RD_I,
	input wire logic [7:0] RDATA_O,
	input wire logic       IRQ_O,
	input wire logic       SCK_I,
	input wire logic       SCK_O,
	input wire logic       SCK_OE_O,
	input wire logic       MOSI_I,
	input wire logic       MOSI_O,
	input wire logic       MOSI_OE_O,
	input wire logic       MISO_I,
	input wire logic       MISO_O,
	input wire logic       MISO_OE_O,
	input wire logic       SS_N_I
);
	// ****
	// Control shadow and properties
	// ****
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	logic [7:0] ctrl_q;
	logic       oe_seen_q;

	// Shadow of software control writes
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			ctrl_q    <= 8'h00;
			oe_seen_q <= 1'b0;
		end
		else if (WR_I && ADDR_I == spmsp_pkg::SPMSP_OFS_CTRL)
		begin
			ctrl_q    <= WDATA_I;
			oe_seen_q <= oe_seen_q | WDATA_I[spmsp_pkg::SPMSP_CR_OE];
		end
	end

	pins_off_a: assert property (!oe_seen_q |-> !SCK_OE_O && !MOSI_OE_O && !MISO_OE_O)
		else $error("pins driven before enable");
	master_pins_a: assert property (SCK_OE_O |-> MOSI_OE_O && !MISO_OE_O)
		else $error("master pin roles wrong");
	fault_drop_a: assert property (SCK_OE_O && !SS_N_I |-> ##[1:3] !SCK_OE_O)
		else $error("select low did not drop master");
	sck_idle_a: assert property ($rose(SCK_OE_O) |-> SCK_O == ctrl_q[3])
		else $error("clock idle level wrong");
	sck_half_a: assert property (SCK_OE_O && SS_N_I && $changed(SCK_O) |=> $stable(SCK_O))
		else $error("clock half period too short");
	irq_cause_a: assert property ($rose(IRQ_O) |-> ctrl_q[7] || $past(ctrl_q[7]))
		else $error("request without enable");
	irq_mask_a: assert property (!ctrl_q[7] && !$past(ctrl_q[7]) |-> !IRQ_O)
		else $error("masked request raised");
	stat_resv_a: assert property ($past(RD_I) && $past(ADDR_I) == 8'h23
		|-> RDATA_O[5] == 1'b0 && RDATA_O[3:0] == 4'h0)
		else $error("unused status bits set");

	cover property ($rose(IRQ_O));
	cover property (SCK_OE_O && !SS_N_I);
	cover property (SCK_OE_O && $changed(SCK_O));
endmodule

bind spmsp_top spmsp_top_asserts u_chk (.CLK_I, .RST_N_I, .ADDR_I, .WDATA_I, .WR_I,
	.RD_I, .RDATA_O, .IRQ_O, .SCK_I, .SCK_O, .SCK_OE_O, .MOSI_I, .MOSI_O, .MOSI_OE_O,
	.MISO_I, .MISO_O, .MISO_OE_O, .SS_N_I);

`default_nettype wire

// file: bench/tb_top.sv
// Bench: master bytes at every rate, collision, fault, slave role, mid-run reset.
// Assumes the package, the top and the slave model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	// ****
	// Stimulus, model and checks
	// ****
	logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ss_n = 1'b1;
	logic       mss_n = 1'b1, pol = 1'b0, pha = 1'b0, m_sck = 1'b0, m_mosi = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] addr = 8'h00, wdata = 8'h00, mtx = 8'h00, rdata, mrx;
	logic       irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, m_miso;
	integer     seed = 32'hD243AB98, err_count = 0, check_count = 0, cyc = 0, i;
	wire        sck_i  = sck_oe ? sck_o : m_sck;
	wire        mosi_i = mosi_oe ? mosi_o : m_mosi;
	wire        miso_i = miso_oe ? miso_o : m_miso;

	always #2 clk = ~clk;

	spmsp_top dut (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .SCK_I(sck_i),
		.SCK_O(sck_o), .SCK_OE_O(sck_oe), .MOSI_I(mosi_i), .MOSI_O(mosi_o),
		.MOSI_OE_O(mosi_oe), .MISO_I(miso_i), .MISO_O(miso_o),
		.MISO_OE_O(miso_oe), .SS_N_I(ss_n));
	spmsp_slave_model u_slv (.clk_i(clk), .sck_i(sck_i), .mosi_i(mosi_i),
		.ss_n_i(mss_n), .clock_idle_level_i(pol), .clock_capture_phase_i(pha), .tx_i(mtx), .miso_o(m_miso),
		.rx_o(mrx));

	// Compare one byte
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask

	// One write cycle
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	// One read cycle, data taken in the following cycle
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask

	// Read and compare
	task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd_reg(a, v);
		chk(n, e, v);
	endtask

	// Half serial period in system cycles for a rate code
	function automatic integer half_of(input logic [2:0] c);
		case (c)
			3'h4: return 2;
			3'h0: return 4;
			3'h1: return 8;
			3'h6: return 16;
			3'h2: return 32;
			default: return 64;
		endcase
	endfunction

	// Master byte with a collided write in flight
	task automatic xfer(input logic [2:0] c);
		logic [7:0] d, v;
		logic       ie, p, q;
		integer     t0, n, h, r;
		r = $random(seed);
		{ie, p, q, d} = r[10:0];
		h = 16 * half_of(c);
		pol <= p;
		pha <= q;
		mtx <= r[18:11];
		exp_q.push_back(r[18:11]);
		wr_reg(8'h22, {ie, 1'b1, c[2], 1'b1, p, q, c[1:0]});
		repeat (2) @(posedge clk);
		#1 chk("idle clock", {7'h0, p}, {7'h0, sck_o});
		chk("clock driven", 8'h01, {7'h0, sck_oe});
		mss_n <= 1'b0;
		wr_reg(8'h21, d);
		t0 = cyc;
		wr_reg(8'h21, ~d);
		n = 0;
		v = 8'h00;
		while (v[7] !== 1'b1 && n < 600)
		begin
			rd_reg(8'h23, v);
			n++;
		end
		t0 = cyc - t0;
		chk("byte time", 8'h01, {7'h0, t0 >= h && t0 <= h + 6});
		chk("status flags", 8'hC0, v);
		chk("request", {7'h0, ie}, {7'h0, irq});
		chk("slave byte", d, mrx);
		mss_n <= 1'b1;
		wr_reg(8'h21, 8'h5A);
		rchk("status clear", 8'h23, 8'h00);
		chk("no restart", {7'h0, p}, {7'h0, sck_o});
		rchk("rx buffer", 8'h21, exp_q.pop_front());
		chk("request off", 8'h00, {7'h0, irq});
		$display("test rate code %0d done", c);
	endtask

	// Select pulled low while master
	task automatic fault_test;
		wr_reg(8'h22, 8'hD0);
		ss_n <= 1'b0;
		repeat (3) @(posedge clk);
		ss_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("fault request", 8'h01, {7'h0, irq});
		rchk("control after fault", 8'h22, 8'h80);
		wr_reg(8'h22, 8'hD0);
		rchk("refused enable", 8'h22, 8'h80);
		rchk("fault flag", 8'h23, 8'h10);
		wr_reg(8'h22, 8'h50);
		rchk("fault clear", 8'h23, 8'h00);
		rchk("enable restored", 8'h22, 8'h50);
		$display("test fault done");
	endtask

	// Far master clocks one byte through the port in slave role
	task automatic slave_test(input logic q);
		logic [7:0] d, e, v;
		integer     r, k;
		r = $random(seed);
		{d, e} = r[15:0];
		v = 8'h00;
		exp_q.push_back(d);
		// Rate bits set but unused in slave role
		wr_reg(8'h22, {5'h08, q, 2'h3});
		wr_reg(8'h21, e);
		ss_n <= 1'b0;
		for (k = 7; k >= 0; k--)
		begin
			if (!q)
				m_mosi <= d[k];
			repeat (4) @(posedge clk);
			m_sck <= 1'b1;
			if (q)
				m_mosi <= d[k];
			else
				v = {v[6:0], miso_i};
			if (k == 4)
				wr_reg(8'h21, ~e);
			repeat (4) @(posedge clk);
			m_sck <= 1'b0;
			if (q)
				v = {v[6:0], miso_i};
		end
		repeat (2) @(posedge clk);
		#1 chk("slave pins", 8'h01, {6'h0, sck_oe, miso_oe});
		@(posedge clk);
		ss_n <= 1'b1;
		chk("slave sent", e, v);
		rchk("slave status", 8'h23, 8'hC0);
		chk("slave request", 8'h00, {7'h0, irq});
		rchk("slave rx", 8'h21, exp_q.pop_front());
		rchk("slave clear", 8'h23, 8'h00);
		$display("test slave phase %0d done", q);
	endtask

	// Counts and verdict
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Cycle count and hang guard
	always @(negedge clk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			give_verdict;
		end
	end

	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rchk("status reset", 8'h23, 8'h00);
		rchk("unmapped", 8'h30, 8'h00);
		rchk("control reset", 8'h22, 8'h00);
		$display("test reset done");
		for (i = 0; i < 8; i++)
			xfer(i[2:0]);
		fault_test;
		slave_test(1'b0);
		slave_test(1'b1);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rchk("control after reset", 8'h22, 8'h00);
		chk("pins after reset", 8'h00, {5'h0, sck_oe, mosi_oe, miso_oe});
		$display("test mid-run reset done");
		give_verdict;
	end
endmodule

`default_nettype wire
